// >>> inc/adc_pkg.sv
package adc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_BUS_CFG   = 8'h00;
  localparam logic [7:0] ADDR_RST_PWR   = 8'h01;
  localparam logic [7:0] ADDR_CLK_CFG   = 8'h02;
  // Reset values
  localparam logic [7:0] RST_BUS_CFG    = 8'hC0;
  localparam logic [7:0] RST_RST_PWR    = 8'h04;
  localparam logic [7:0] RST_CLK_CFG    = 8'h00;
  // Field positions
  localparam int         BIT_ADDR_SEL   = 0;
  localparam int         BIT_ANA_PWDN   = 5;
  localparam int         BIT_SOFT_RST   = 1;
  localparam int         BIT_FULL_RST   = 0;
  localparam int         BIT_AUTO_CLK   = 5;
  // Reset pulse length in cycles
  localparam logic [3:0] RST_PULSE_CYC  = 4'h4;
  // Clock output source
  typedef enum logic [1:0]
  {
    ADC_CLK_OFF = 2'h0,
    ADC_CLK_SYS = 2'h1,
    ADC_CLK_OSC = 2'h3
  } adc_clk_src_e;
endpackage : adc_pkg

// >>> design/adc_ctrl_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// (R1) Registers reachable from local bus and remote channel
// (R2) Unlisted addresses are reserved, read zero
// (R3) Host keeps reserved fields at their defaults
// (R4) Address register bits 7:1 hold own address
// (R5) Bit 0 picks strap or programmed address
// (R6) Reset register bit 5 powers analog down
// (R7) Analog power-down writable only from local bus
// (R8) Bit 1 resets logic, keeps registers, self-clears
// (R9) Bit 0 resets everything to defaults, self-clears
// (R10) Auto-clock picks oscillator when link unlocked
// (R11) Reset bits read zero once reset done
// (R12) Local and remote writes serialised, local first
module adc_ctrl_regs
  import adc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Local control bus register port
  input  wire logic       loc_wr,
  input  wire logic       loc_rd,
  input  wire logic [7:0] loc_addr,
  input  wire logic [7:0] loc_wdata,
  output logic      [7:0] loc_rdata,
  output logic            loc_rvalid,
  // Remote back channel register port
  input  wire logic       rem_wr,
  input  wire logic       rem_rd,
  input  wire logic [7:0] rem_addr,
  input  wire logic [7:0] rem_wdata,
  output logic      [7:0] rem_rdata,
  output logic            rem_rvalid,
  output logic            rem_wr_busy,
  // Pins and status
  input  wire logic [6:0] address_strap_pins,
  input  wire logic       link_a,
  // Controls out
  output logic      [6:0] own_bus_address,
  output logic            analog_power_down,
  output logic            logic_reset,
  output logic      [1:0] clk_out_src
);

  // Register state
  logic [7:0] bus_cfg_q, bus_cfg_d;
  logic       pwdn_q, pwdn_d;
  logic       auto_clk_q, auto_clk_d;
  logic [3:0] soft_cnt_q, soft_cnt_d;
  logic [3:0] full_cnt_q, full_cnt_d;
  logic       rem_pend_q, rem_pend_d;
  logic [7:0] rem_pa_q, rem_pa_d, rem_pd_q, rem_pd_d;
  logic [6:0] strap_s1_q, strap_s2_q, strap_s1_d, strap_s2_d;
  logic       lock_s1_q, lock_s2_q, lock_s1_d, lock_s2_d;
  logic [7:0] lrd_q, lrd_d, rrd_q, rrd_d;
  logic       lrv_q, lrv_d, rrv_q, rrv_d;
  logic [6:0] addr_q, addr_d;
  logic [1:0] src_q, src_d;
  logic       rst_out_q, rst_out_d;

  // Readback decode shared by both ports
  function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] cfg,
                                        input logic pd, input logic [3:0] sc,
                                        input logic [3:0] fc, input logic ac);
    logic [7:0] r;
    r = 8'h00; // (R2)
    case (a)
      ADDR_BUS_CFG: r = cfg;
      ADDR_RST_PWR:
      begin
        r = RST_RST_PWR;
        r[BIT_ANA_PWDN] = pd;
        r[BIT_SOFT_RST] = (sc != 4'h0); // (R11)
        r[BIT_FULL_RST] = (fc != 4'h0); // (R11)
      end
      ADDR_CLK_CFG:
      begin
        r = RST_CLK_CFG;
        r[BIT_AUTO_CLK] = ac;
      end
      default: r = 8'h00;
    endcase
    return r;
  endfunction : rd_mux

  // Next-state logic; the full reset wins over every write
  always_comb
  begin
    logic       wr_en;
    logic       wr_loc;
    logic [7:0] wa;
    logic [7:0] wd;
    wr_en = 1'b0;
    wr_loc = 1'b0;
    wa = 8'h00;
    wd = 8'h00;
    bus_cfg_d = bus_cfg_q;
    pwdn_d = pwdn_q;
    auto_clk_d = auto_clk_q;
    soft_cnt_d = (soft_cnt_q != 4'h0) ? soft_cnt_q - 4'h1 : 4'h0; // (R8)
    full_cnt_d = (full_cnt_q != 4'h0) ? full_cnt_q - 4'h1 : 4'h0; // (R9)
    rem_pend_d = rem_pend_q;
    rem_pa_d = rem_pa_q;
    rem_pd_d = rem_pd_q;
    strap_s1_d = address_strap_pins;
    strap_s2_d = strap_s1_q;
    lock_s1_d = link_a;
    lock_s2_d = lock_s1_q;
    // Remote write parks until the local bus is idle (R12)
    if (rem_wr && !rem_pend_q)
    begin
      rem_pend_d = 1'b1;
      rem_pa_d = rem_addr;
      rem_pd_d = rem_wdata;
    end
    if (loc_wr)
    begin
      wr_en = 1'b1; // (R1)
      wr_loc = 1'b1;
      wa = loc_addr;
      wd = loc_wdata;
    end
    else if (rem_pend_q)
    begin
      wr_en = 1'b1; // (R1) (R12)
      wa = rem_pa_q;
      wd = rem_pd_q;
      rem_pend_d = 1'b0;
    end
    if (wr_en && full_cnt_q == 4'h0)
    begin
      case (wa)
        ADDR_BUS_CFG: bus_cfg_d = wd; // (R4)
        ADDR_RST_PWR:
        begin
          if (wr_loc)
            pwdn_d = wd[BIT_ANA_PWDN]; // (R6) (R7)
          if (wd[BIT_SOFT_RST])
            soft_cnt_d = RST_PULSE_CYC; // (R8)
          if (wd[BIT_FULL_RST])
            full_cnt_d = RST_PULSE_CYC; // (R9)
        end
        ADDR_CLK_CFG: auto_clk_d = wd[BIT_AUTO_CLK];
        default: ; // (R2)
      endcase
    end
    // Registers return to defaults while the full reset runs
    if (full_cnt_q != 4'h0)
    begin
      bus_cfg_d = RST_BUS_CFG; // (R9)
      pwdn_d = RST_RST_PWR[BIT_ANA_PWDN];
      auto_clk_d = RST_CLK_CFG[BIT_AUTO_CLK];
      rem_pend_d = 1'b0;
    end
    lrd_d = rd_mux(loc_addr, bus_cfg_q, pwdn_q, soft_cnt_q, full_cnt_q, auto_clk_q);
    rrd_d = rd_mux(rem_addr, bus_cfg_q, pwdn_q, soft_cnt_q, full_cnt_q, auto_clk_q);
    lrv_d = loc_rd;
    rrv_d = rem_rd;
    // Reset flag from next counter values, so the flop tracks the counters exactly
    rst_out_d = (soft_cnt_d != 4'h0) | (full_cnt_d != 4'h0); // (R8) (R9)
    // Address source select (R5)
    addr_d = bus_cfg_q[BIT_ADDR_SEL] ? bus_cfg_q[7:1] : strap_s2_q;
    // Clock source follows lock state (R10)
    if (lock_s2_q)
      src_d = ADC_CLK_SYS;
    else if (auto_clk_q)
      src_d = ADC_CLK_OSC;
    else
      src_d = ADC_CLK_OFF;
  end

  // State registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      bus_cfg_q <= RST_BUS_CFG;
      pwdn_q <= RST_RST_PWR[BIT_ANA_PWDN];
      auto_clk_q <= RST_CLK_CFG[BIT_AUTO_CLK];
      soft_cnt_q <= 4'h0;
      full_cnt_q <= 4'h0;
      rem_pend_q <= 1'b0;
      rem_pa_q <= 8'h00;
      rem_pd_q <= 8'h00;
      strap_s1_q <= 7'h00;
      strap_s2_q <= 7'h00;
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      lrd_q <= 8'h00;
      rrd_q <= 8'h00;
      lrv_q <= 1'b0;
      rrv_q <= 1'b0;
      addr_q <= 7'h00;
      src_q <= ADC_CLK_OFF;
      rst_out_q <= 1'b0;
    end
    else
    begin
      bus_cfg_q <= bus_cfg_d;
      pwdn_q <= pwdn_d;
      auto_clk_q <= auto_clk_d;
      soft_cnt_q <= soft_cnt_d;
      full_cnt_q <= full_cnt_d;
      rem_pend_q <= rem_pend_d;
      rem_pa_q <= rem_pa_d;
      rem_pd_q <= rem_pd_d;
      strap_s1_q <= strap_s1_d;
      strap_s2_q <= strap_s2_d;
      lock_s1_q <= lock_s1_d;
      lock_s2_q <= lock_s2_d;
      lrd_q <= lrd_d;
      rrd_q <= rrd_d;
      lrv_q <= lrv_d;
      rrv_q <= rrv_d;
      addr_q <= addr_d;
      src_q <= src_d;
      rst_out_q <= rst_out_d;
    end
  end

  // Outputs straight from flops
  assign loc_rdata = lrd_q;
  assign loc_rvalid = lrv_q;
  assign rem_rdata = rrd_q;
  assign rem_rvalid = rrv_q;
  assign rem_wr_busy = rem_pend_q;
  assign own_bus_address = addr_q;
  assign analog_power_down = pwdn_q;
  assign logic_reset = rst_out_q; // Both resets hit logic
  assign clk_out_src = src_q;

endmodule : adc_ctrl_regs
`default_nettype wire

// >>> verification/adc_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Port timing and reset control checks
module adc_asserts
  import adc_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // Watched ports
  input wire logic       loc_wr,
  input wire logic       loc_rd,
  input wire logic [7:0] loc_addr,
  input wire logic [7:0] loc_wdata,
  input wire logic       loc_rvalid,
  input wire logic       rem_wr,
  input wire logic       rem_rd,
  input wire logic       rem_rvalid,
  input wire logic       rem_wr_busy,
  input wire logic       analog_power_down,
  input wire logic       logic_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Local write to the reset register outside a reset pulse
  wire logic rw = loc_wr && loc_addr == ADDR_RST_PWR && !logic_reset;
  a_loc_rd_ans: assert property (loc_rd |=> loc_rvalid)
    else $error("local read unanswered");
  a_loc_rd_idle: assert property (!loc_rd |=> !loc_rvalid)
    else $error("stray local valid");
  a_rem_rd_ans: assert property (rem_rd |=> rem_rvalid)
    else $error("remote read unanswered");
  a_rem_park: assert property (rem_wr && !rem_wr_busy && !logic_reset |=> rem_wr_busy)
    else $error("remote write not parked");
  a_rem_drain: assert property (rem_wr_busy && !loc_wr |=> !rem_wr_busy)
    else $error("remote write stuck");
  a_soft_pulse: assert property (rw && loc_wdata[1:0] == 2'h2 |=> logic_reset [*4] ##1 !logic_reset)
    else $error("soft reset pulse wrong");
  a_pwdn_set: assert property (rw && loc_wdata[1:0] == 2'h0 |=> ##1 analog_power_down == $past(loc_wdata[5], 2))
    else $error("power down not taken");
  a_pwdn_local: assert property ($rose(analog_power_down) |-> $past(loc_wr) || $past(loc_wr, 2))
    else $error("power down without local write");
endmodule : adc_asserts
bind adc_ctrl_regs adc_asserts u_chk (.*);
`default_nettype wire

// >>> verification/adc_rem_model.sv
`timescale 1ns/10ps
`default_nettype none
// Remote serializer end of the back channel
module adc_rem_model
  import adc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] rem_rdata,
  output logic            rem_wr,
  output logic            rem_rd,
  output logic      [7:0] rem_addr,
  output logic      [7:0] rem_wdata
);
  initial {rem_wr, rem_rd, rem_addr, rem_wdata} = '0;
  // One access; released lines toggle so stale values never look valid
  task automatic go(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge sys_clk);
    {rem_wr, rem_rd, rem_addr} = {w, !w, a};
    rem_wdata = a == 1 ? d & 8'h23 | RST_RST_PWR : a == 2 ? d & 8'h20 : d;
    @(negedge sys_clk);
    q = rem_rdata;
    {rem_wr, rem_rd, rem_addr, rem_wdata} = {2'h0, ~a, ~rem_wdata};
  endtask : go
endmodule : adc_rem_model
`default_nettype wire

// >>> verification/adc_ctrl_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module adc_ctrl_regs_tb
  import adc_pkg::*;
;
  logic       sys_clk = 0, sys_rst = 1, loc_wr = 0, loc_rd = 0, link_a = 0, rv, pd, rw, rr;
  logic [7:0] loc_addr = 0, loc_wdata = 0, loc_rdata, rem_rdata, q, ra, rd;
  logic [7:0] m [3];
  logic       rrv, busy, lrst;
  logic [6:0] straps = 0, own;
  logic [1:0] src;
  int         err_count = 0, checked = 0, seed = 32'hf83e, i;
  adc_ctrl_regs DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .loc_wr(loc_wr), .loc_rd(loc_rd),
    .loc_addr(loc_addr), .loc_wdata(loc_wdata), .loc_rdata(loc_rdata), .loc_rvalid(rv),
    .rem_wr(rw), .rem_rd(rr), .rem_addr(ra), .rem_wdata(rd), .rem_rdata(rem_rdata),
    .rem_rvalid(rrv), .rem_wr_busy(busy), .address_strap_pins(straps), .link_a(link_a),
    .own_bus_address(own), .analog_power_down(pd), .logic_reset(lrst), .clk_out_src(src));
  adc_rem_model u_rem (.sys_clk(sys_clk), .rem_rdata(rem_rdata), .rem_wr(rw), .rem_rd(rr),
    .rem_addr(ra), .rem_wdata(rd));
  initial forever #2 sys_clk = ~sys_clk;
  // Local write, reserved fields driven at default; model keeps the settled readback
  task automatic lw(input logic [7:0] a, d);
    logic [7:0] v;
    v = a == 1 ? d & 8'h23 | RST_RST_PWR : a == 2 ? d & 8'h20 : d;
    @(negedge sys_clk);
    {loc_wr, loc_addr, loc_wdata} = {1'b1, a, v};
    if (a < 3) m[a] = a == 1 ? v & 8'h24 : v;
    @(negedge sys_clk);
    loc_wr = 0;
  endtask : lw
  // Local read against the model; unmapped reads zero
  task automatic lrd(input logic [7:0] a);
    @(negedge sys_clk);
    {loc_rd, loc_addr} = {1'b1, a};
    @(negedge sys_clk);
    loc_rd = 0;
    `CHK({rv, loc_rdata}, {1'b1, a < 3 ? m[a] : 8'h00})
  endtask : lrd
  task automatic end_sim;
    $display("mismatches %0d compares %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  // Hang guard, far beyond the expected 142 cycles
  initial begin #20000; err_count++; end_sim; end
  initial begin
    m = '{RST_BUS_CFG, RST_RST_PWR, RST_CLK_CFG};
    repeat (10) @(negedge sys_clk);
    sys_rst = 0;
    for (i = 0; i < 8; i++) lrd(8'(i));
    repeat (6) begin
      straps = 7'($random(seed));
      lw(0, 8'($random(seed)));
      repeat (4) @(negedge sys_clk);
      `CHK(own, m[0][0] ? m[0][7:1] : straps)
      u_rem.go(0, 0, 0, q);
      `CHK({rrv, q}, {1'b1, m[0]})
    end
    u_rem.go(1, 1, 8'h20, q);
    `CHK(busy, 1'b1)
    lrd(1);
    `CHK(pd, 1'b0)
    `CHK(busy, 1'b0)
    lw(1, 8'h20);
    lrd(1);
    `CHK(pd, 1'b1)
    for (i = 0; i < 4; i++) begin
      link_a = i[0];
      lw(2, {2'h0, i[1], 5'h0});
      repeat (5) @(negedge sys_clk);
      `CHK(src, i[0] ? ADC_CLK_SYS : i[1] ? ADC_CLK_OSC : ADC_CLK_OFF)
    end
    fork
      lw(2, 8'h00);
      u_rem.go(1, 0, 8'hA3, q);
    join
    `CHK(busy, 1'b1)
    m[0] = 8'hA3;
    lrd(0);
    lrd(2);
    lw(1, 8'h22);
    `CHK(lrst, 1'b1)
    m[1] = 8'h26;
    lrd(1);
    m[1] = 8'h24;
    repeat (4) @(negedge sys_clk);
    `CHK(lrst, 1'b0)
    lrd(1);
    lrd(0);
    lw(1, 8'h01);
    `CHK(lrst, 1'b1)
    m[1] = 8'h05;
    lrd(1);
    m = '{RST_BUS_CFG, RST_RST_PWR, RST_CLK_CFG};
    repeat (4) @(negedge sys_clk);
    `CHK(lrst, 1'b0)
    for (i = 0; i < 3; i++) lrd(8'(i));
    `CHK(pd, 1'b0)
    end_sim;
  end
endmodule : adc_ctrl_regs_tb
`default_nettype wire
